// >>> core/ccu_defs.vh
/*
 * Constants for the capture/compare/PWM unit: register offsets, field
 * positions, mode codes and reset values.
 * Assumes inclusion by bare name from files under core/.
 */
`ifndef CCU_DEFS_VH
`define CCU_DEFS_VH

// ------------------------------------------------------------
// register offsets (byte address on the plain register port)
// ------------------------------------------------------------
`define CCU_A_MODE 4'h0
`define CCU_A_HOLD_LO 4'h1
`define CCU_A_HOLD_HI 4'h2
`define CCU_A_DEAD_BAND 4'h3
`define CCU_A_SHUTDOWN 4'h4
`define CCU_A_STATUS 4'h5
`define CCU_A_MASK 4'h6
`define CCU_A_TIMER_LO 4'h7
`define CCU_A_TIMER_HI 4'h8
`define CCU_A_TIMER_CTL 4'h9

// ------------------------------------------------------------
// mode codes, low nibble of mode_control
// ------------------------------------------------------------
`define CCU_M_OFF 4'h0
`define CCU_M_CMP_TOGGLE 4'h2
`define CCU_M_CAP_FALL 4'h4
`define CCU_M_CAP_RISE 4'h5
`define CCU_M_CAP_RISE4 4'h6
`define CCU_M_CAP_RISE16 4'h7
`define CCU_M_CMP_SET 4'h8
`define CCU_M_CMP_CLR 4'h9
`define CCU_M_CMP_IRQ 4'ha
`define CCU_M_CMP_SPECIAL 4'hb

// ------------------------------------------------------------
// mode_control upper fields: bridge steering and pwm duty lsbs
// ------------------------------------------------------------
`define CCU_F_STEER_HI 7
`define CCU_F_STEER_LO 6
`define CCU_F_DUTYLSB_HI 5
`define CCU_F_DUTYLSB_LO 4
`define CCU_STEER_SINGLE 2'h0
`define CCU_STEER_FULL_FWD 2'h1
`define CCU_STEER_HALF 2'h2
`define CCU_STEER_FULL_REV 2'h3

// ------------------------------------------------------------
// status / mask bits
// ------------------------------------------------------------
`define CCU_S_EVENT 0
`define CCU_S_SHUTDOWN 1
`define CCU_S_WRAP 2

// ------------------------------------------------------------
// auto-shutdown control fields
// ------------------------------------------------------------
`define CCU_F_SD_EN 0
`define CCU_F_SD_RESTART 1
`define CCU_F_SD_ACTIVE 7

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define CCU_RST_BYTE 8'h00
`define CCU_RST_WORD 16'h0000
`define CCU_RST_TCTL 8'h01

`endif

// >>> core/ccu_edge_prescale.v
/*
 * Edge detector and prescaler for the capture input: emits a one-cycle
 * pulse on the selected falling edge, rising edge, or 4th / 16th rising edge.
 * Assumes the pin input is already synchronous to clk.
 */
`timescale 1ns/1ps
`default_nettype none
`include "ccu_defs.vh"

module ccu_edge_prescale (
	input wire clk,
	input wire rst_n,
	input wire pin_in,
	input wire [3:0] mode,
	output reg event_p
);

	reg pin_q;
	reg [3:0] count_q;
	reg [3:0] mode_q;
	wire rise;
	wire fall;

	assign rise = pin_in & ~pin_q;
	assign fall = ~pin_in & pin_q;

	// prescale count restarts whenever the mode changes so the first
	// capture after reprogramming is a full 4 or 16 edges away
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pin_q <= 1'b0;
			count_q <= 4'h0;
			mode_q <= 4'h0;
			event_p <= 1'b0;
		end else begin
			pin_q <= pin_in;
			mode_q <= mode;
			event_p <= 1'b0;
			if (mode != mode_q) begin
				count_q <= 4'h0;
			end else begin
				case (mode)
				`CCU_M_CAP_FALL: event_p <= fall;
				`CCU_M_CAP_RISE: event_p <= rise;
				`CCU_M_CAP_RISE4: begin
					if (rise) begin
						count_q <= (count_q[1:0] == 2'h3) ? 4'h0 : count_q + 4'h1;
						event_p <= (count_q[1:0] == 2'h3);
					end
				end
				`CCU_M_CAP_RISE16: begin
					if (rise) begin
						count_q <= count_q + 4'h1;
						event_p <= (count_q == 4'hf);
					end
				end
				default: count_q <= 4'h0;
				endcase
			end
		end
	end

endmodule
`default_nettype wire

// >>> core/ccu_top.v
/*
 * Capture/compare/PWM unit with its 16-bit timebase counter, enhanced
 * bridge steering, dead band and auto-shutdown, and a register port.
 * Assumes a 200 MHz clock, synchronous pin inputs, and that software sets
 * the pin direction itself; pin_oe here only reflects the active mode.
 */
`timescale 1ns/1ps
`default_nettype none
`include "ccu_defs.vh"

// How it works
// - capture event copies counter into holding register
// - low mode nibble picks capture edge
// - pwm steering for full and half bridge
// - dead band on half-bridge pwm, auto-shutdown on all pwm
// - compare match acts on pin in set, clear and toggle modes, raises event
// - special trigger clears counter, starts conversion
module ccu_top (
	input wire clk,
	input wire arst_n,
	input wire [3:0] addr,
	input wire [7:0] wdata,
	input wire wr,
	input wire rd,
	output reg [7:0] rdata,
	input wire pin_in,
	input wire shutdown_in,
	input wire adc_enabled,
	output reg pin_out,
	output reg pin_oe,
	output reg [3:0] bridge_out,
	output reg adc_start,
	output reg irq
);

	// ------------------------------------------------------------
	// reset release
	// ------------------------------------------------------------
	reg rst_s1_q;
	reg rst_n_q;
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rst_s1_q <= 1'b0;
			rst_n_q <= 1'b0;
		end else begin
			rst_s1_q <= 1'b1;
			rst_n_q <= rst_s1_q;
		end
	end

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	reg [7:0] mode_q;
	reg [15:0] hold_q;
	reg [7:0] dead_q;
	reg [7:0] sd_q;
	reg [2:0] status_q;
	reg [2:0] mask_q;
	reg [15:0] timer_q;
	reg [7:0] tctl_q;
	reg [7:0] pwm_cnt_q;
	reg [7:0] dead_cnt_q;
	reg pwm_raw_q;
	reg pwm_prev_q;
	reg cmp_pin_q;

	wire [3:0] m;
	wire cap_mode;
	wire cmp_mode;
	wire pwm_mode;
	wire cap_evt;
	wire match;
	wire wr_mode;
	wire wr_status;
	wire [2:0] set_bits;
	wire [9:0] duty;

	assign m = mode_q[3:0];
	assign cap_mode = (m[3:2] == 2'h1);
	assign cmp_mode = (m[3] == 1'b1 && m[3:2] != 2'h3) || (m == `CCU_M_CMP_TOGGLE);
	assign pwm_mode = (m[3:2] == 2'h3);
	assign match = cmp_mode && tctl_q[0] && (timer_q == hold_q);
	assign wr_mode = wr && (addr == `CCU_A_MODE);
	assign wr_status = wr && (addr == `CCU_A_STATUS);
	assign duty = {hold_q[7:0], mode_q[`CCU_F_DUTYLSB_HI:`CCU_F_DUTYLSB_LO]};

	ccu_edge_prescale u_edge (
		.clk(clk),
		.rst_n(rst_n_q),
		.pin_in(pin_in),
		.mode(m),
		.event_p(cap_evt)
	);

	// match stays true while the counter sits on the compare value,
	// so only its first cycle counts as an event
	reg match_prev_q;
	wire match_p;
	assign match_p = match && !match_prev_q;
	wire sd_trip;
	assign sd_trip = pwm_mode && sd_q[`CCU_F_SD_EN] && shutdown_in;
	wire wrap;
	assign wrap = tctl_q[0] && (timer_q == 16'hffff);
	assign set_bits = {wrap, sd_trip, (cap_mode && cap_evt) | match_p};

	// ------------------------------------------------------------
	// register writes, capture, timebase
	// ------------------------------------------------------------
	always @(posedge clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			mode_q <= `CCU_RST_BYTE;
			hold_q <= `CCU_RST_WORD;
			dead_q <= `CCU_RST_BYTE;
			sd_q <= `CCU_RST_BYTE;
			mask_q <= 3'h0;
			status_q <= 3'h0;
			timer_q <= `CCU_RST_WORD;
			tctl_q <= `CCU_RST_TCTL;
			match_prev_q <= 1'b0;
		end else begin
			match_prev_q <= match;
			if (wr_mode) mode_q <= wdata;
			if (wr && addr == `CCU_A_DEAD_BAND) dead_q <= wdata;
			if (wr && addr == `CCU_A_MASK) mask_q <= wdata[2:0];
			if (wr && addr == `CCU_A_TIMER_CTL) tctl_q <= wdata;
			// capture wins over a software write of the same cycle
			if (cap_mode && cap_evt) begin
				hold_q <= timer_q;
			end else begin
				if (wr && addr == `CCU_A_HOLD_LO) hold_q[7:0] <= wdata;
				if (wr && addr == `CCU_A_HOLD_HI) hold_q[15:8] <= wdata;
			end
			// set wins over write-one-to-clear
			status_q <= (status_q & ~(wr_status ? wdata[2:0] : 3'h0)) | set_bits;
			// shutdown latch: trip sets it, auto-restart or a write clears it
			if (sd_trip) begin
				sd_q <= {1'b1, sd_q[6:0]};
			end else if (wr && addr == `CCU_A_SHUTDOWN) begin
				sd_q <= {wdata[`CCU_F_SD_ACTIVE] & sd_q[`CCU_F_SD_ACTIVE], wdata[6:0]};
			end else if (sd_q[`CCU_F_SD_RESTART] && !shutdown_in) begin
				sd_q <= {1'b0, sd_q[6:0]};
			end
			if (wr && addr == `CCU_A_TIMER_LO) begin
				timer_q[7:0] <= wdata;
			end else if (wr && addr == `CCU_A_TIMER_HI) begin
				timer_q[15:8] <= wdata;
			end else if (match_p && m == `CCU_M_CMP_SPECIAL) begin
				timer_q <= `CCU_RST_WORD;
			end else if (tctl_q[0]) begin
				timer_q <= timer_q + 16'h0001;
			end
		end
	end

	// ------------------------------------------------------------
	// compare pin action, pwm and dead band
	// ------------------------------------------------------------
	always @(posedge clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			cmp_pin_q <= 1'b0;
			pwm_cnt_q <= 8'h00;
			pwm_raw_q <= 1'b0;
			pwm_prev_q <= 1'b0;
			dead_cnt_q <= 8'h00;
		end else begin
			if (wr_mode && wdata[3:0] != m) begin
				// compare-set starts low, compare-clear starts high
				cmp_pin_q <= (wdata[3:0] == `CCU_M_CMP_CLR);
			end else if (match_p) begin
				case (m)
				`CCU_M_CMP_SET: cmp_pin_q <= 1'b1;
				`CCU_M_CMP_CLR: cmp_pin_q <= 1'b0;
				`CCU_M_CMP_TOGGLE: cmp_pin_q <= ~cmp_pin_q;
				default: cmp_pin_q <= cmp_pin_q;
				endcase
			end
			// 10-bit duty over an 8-bit period extended by 2 zero bits
			pwm_cnt_q <= pwm_cnt_q + 8'h01;
			pwm_raw_q <= pwm_mode && ({pwm_cnt_q, 2'h0} < duty);
			pwm_prev_q <= pwm_raw_q;
			// dead band restarts on every edge of the raw waveform
			if (pwm_raw_q != pwm_prev_q) begin
				dead_cnt_q <= dead_q;
			end else if (dead_cnt_q != 8'h00) begin
				dead_cnt_q <= dead_cnt_q - 8'h01;
			end
		end
	end

	wire gap;
	wire act_a;
	wire act_b;
	assign gap = (dead_cnt_q != 8'h00) || (pwm_raw_q != pwm_prev_q);
	assign act_a = pwm_prev_q && !gap;
	assign act_b = !pwm_prev_q && !gap;

	// ------------------------------------------------------------
	// output stage
	// ------------------------------------------------------------
	always @(posedge clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			pin_out <= 1'b0;
			pin_oe <= 1'b0;
			bridge_out <= 4'h0;
			adc_start <= 1'b0;
			irq <= 1'b0;
			rdata <= 8'h00;
		end else begin
			// oe mirrors the mode; pin direction itself is software's duty
			pin_oe <= cmp_mode || pwm_mode;
			adc_start <= match_p && m == `CCU_M_CMP_SPECIAL && adc_enabled;
			irq <= |(status_q & mask_q);
			if (!pwm_mode) begin
				pin_out <= cmp_pin_q;
				bridge_out <= 4'h0;
			end else if (sd_q[`CCU_F_SD_ACTIVE]) begin
				pin_out <= 1'b0;
				bridge_out <= 4'h0;
			end else begin
				pin_out <= pwm_prev_q;
				case (mode_q[`CCU_F_STEER_HI:`CCU_F_STEER_LO])
				`CCU_STEER_SINGLE: bridge_out <= {3'h0, pwm_prev_q};
				`CCU_STEER_HALF: bridge_out <= {2'h0, act_b, act_a};
				`CCU_STEER_FULL_FWD: bridge_out <= {pwm_prev_q, 2'h0, 1'b1};
				`CCU_STEER_FULL_REV: bridge_out <= {1'b0, 1'b1, pwm_prev_q, 1'b0};
				default: bridge_out <= 4'h0;
				endcase
			end
			rdata <= 8'h00;
			if (rd) begin
				case (addr)
				`CCU_A_MODE: rdata <= mode_q;
				`CCU_A_HOLD_LO: rdata <= hold_q[7:0];
				`CCU_A_HOLD_HI: rdata <= hold_q[15:8];
				`CCU_A_DEAD_BAND: rdata <= dead_q;
				`CCU_A_SHUTDOWN: rdata <= sd_q;
				`CCU_A_STATUS: rdata <= {5'h00, status_q};
				`CCU_A_MASK: rdata <= {5'h00, mask_q};
				`CCU_A_TIMER_LO: rdata <= timer_q[7:0];
				`CCU_A_TIMER_HI: rdata <= timer_q[15:8];
				`CCU_A_TIMER_CTL: rdata <= tctl_q;
				default: rdata <= 8'h00;
				endcase
			end
		end
	end

endmodule
`default_nettype wire

// >>> sim/ccu_props.sv
/* checker on the unit's top-level ports: register reads, pin enable,
   conversion start and interrupt; bound into ccu_top below */
`timescale 1ns/1ps
`default_nettype none
module ccu_props (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic [3:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	input wire logic [7:0] rdata,
	input wire logic pin_oe,
	input wire logic adc_enabled,
	input wire logic adc_start,
	input wire logic irq
);
	// ----------------------------------------
	// last mode written, seen from the port
	// ----------------------------------------
	logic [3:0] mq;
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			mq <= 4'h0;
		else if (wr && addr == 4'h0)
			mq <= wdata[3:0];
	end
	default clocking dc @(posedge clk); endclocking
	default disable iff (!arst_n);
	sequence s_mode_wr;
		wr && addr == 4'h0;
	endsequence
	sequence s_mode_rd;
		rd && addr == 4'h0;
	endsequence
	a_mode_readback: assert property (s_mode_wr ##2 s_mode_rd |=> rdata == $past(wdata, 3))
		else $error("mode readback");
	a_oe_by_mode: assert property (s_mode_wr |=> ##1
		pin_oe == ($past(wdata[3], 2) || $past(wdata[3:0], 2) == 4'h2)) else $error("pin_oe");
	a_rdata_idle: assert property (!rd |=> rdata == 8'h00) else $error("stray rdata");
	a_unmapped_zero: assert property (rd && addr > 4'h9 |=> rdata == 8'h00) else $error("unmapped");
	a_adc_pulse: assert property (adc_start |=> !adc_start) else $error("adc_start long");
	// the pulse follows the match cycle, so mode and enable are those of one cycle back
	a_adc_special: assert property (adc_start |-> $past(mq) == 4'hb && $past(adc_enabled))
		else $error("adc_start cause");
	a_irq_masked: assert property (wr && addr == 4'h6 && wdata == 8'h00 |=> ##1 !irq)
		else $error("irq masked");
	a_irq_reset_low: assert property ($rose(arst_n) |-> !irq [*2]) else $error("irq at reset");
endmodule
bind ccu_top ccu_props i_ccu_props (.clk, .arst_n, .addr, .wdata, .wr, .rd, .rdata, .pin_oe,
	.adc_enabled, .adc_start, .irq);
`default_nettype wire

// >>> sim/ccu_pulse_src.sv
/* external pulse source on the unit pin: square wave of 2*half cycles;
   assumes run and half change only at clock edges */
`timescale 1ns/1ps
`default_nettype none
module ccu_pulse_src (
	input wire logic clk,
	input wire logic run,
	input wire logic oe,
	input wire logic [7:0] half,
	output logic pin
);
	// ----------------------------------------
	// waveform
	// ----------------------------------------
	logic [7:0] cnt = 8'h00;
	logic lvl = 1'b0;
	assign pin = lvl;
	// stands still while the unit drives the pin
	always @(posedge clk) begin
		if (run && !oe) begin
			if (cnt >= half - 8'h01) begin
				cnt <= 8'h00;
				lvl <= ~lvl;
			end else
				cnt <= cnt + 8'h01;
		end
	end
endmodule
`default_nettype wire

// >>> sim/capture_compare_pwm_unit_test.sv
/* self-checking bench for ccu_top with a pulse source on its pin;
   assumes the timebase counter runs from reset */
`timescale 1ns/1ps
`default_nettype none
module capture_compare_pwm_unit_test;
	logic clk, arst_n, wr, rd, shutdown_in, adc_enabled, pin_in, run, p;
	logic [3:0] addr;
	logic [7:0] wdata, half, r, b;
	logic [3:0] cm [4] = '{4'h8, 4'h9, 4'h2, 4'ha};
	wire [7:0] rdata;
	wire [3:0] bridge_out;
	wire pin_out, pin_oe, adc_start, irq;
	int n_fail, comparisons;
	logic [7:0] zr;
	int nov, na, nb;
	bit seen;
	ccu_top i_ccu_top (.clk, .arst_n, .addr, .wdata, .wr, .rd, .rdata, .pin_in, .shutdown_in,
		.adc_enabled, .pin_out, .pin_oe, .bridge_out, .adc_start, .irq);
	ccu_pulse_src i_ccu_pulse_src (.clk, .run, .oe(pin_oe), .half, .pin(pin_in));
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic [7:0] nxt(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction
	function automatic logic [7:0] rst_val(input logic [3:0] a);
		return (a == 4'h9) ? 8'h01 : 8'h00;
	endfunction
	function automatic logic pin_next(input logic q, input logic [3:0] m);
		case (m)
			4'h8: return 1'b1;
			4'h9: return 1'b0;
			4'h2: return ~q;
			default: return q;
		endcase
	endfunction
	task automatic close_out;
		$display("comparisons %0d mismatches %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_fail++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wrt(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rdb(input logic [3:0] a);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 b = rdata;
	endtask
	// bounded wait for irq, or for adc_start when adc is set
	task automatic wt(input bit adc);
		for (int i = 0; i < 4000; i++) begin
			@(posedge clk);
			#1;
			if ((adc ? adc_start : irq) === 1'b1)
				return;
		end
		chk(16'h0, 16'h1);
		close_out;
	endtask
	// two captures k events apart must differ by k source periods
	task automatic cap(input logic [3:0] m, input int k);
		logic [15:0] t1, t2;
		logic [7:0] h;
		r = nxt(r);
		h = 8'd20 + {2'b00, r[5:0]};
		@(posedge clk);
		half <= h;
		run <= 1'b1;
		wrt(4'h0, {4'h0, m});
		wrt(4'h5, 8'h01);
		wt(0);
		rdb(4'h2);
		t1[15:8] = b;
		rdb(4'h1);
		t1[7:0] = b;
		wrt(4'h5, 8'h01);
		rdb(4'h1);
		chk(b, t1[7:0]);
		chk(irq, 1'b0);
		wt(0);
		rdb(4'h2);
		t2[15:8] = b;
		rdb(4'h1);
		t2[7:0] = b;
		chk(t2 - t1, 16'(2 * k * h));
	endtask
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		arst_n = 1'b0;
		{wr, rd, shutdown_in, run, p} = 5'h00;
		{addr, wdata, half} = 20'h00028;
		adc_enabled = 1'b1;
		r = 8'd24;
		n_fail = 0;
		comparisons = 0;
		repeat (10) @(posedge clk);
		arst_n <= 1'b1;
		repeat (3) @(posedge clk);
		for (int a = 0; a < 16; a++) begin
			if (a == 7 || a == 8)
				continue;
			rdb(a[3:0]);
			chk(b, rst_val(a[3:0]));
		end
		wrt(4'hc, 8'hff);
		rdb(4'hc);
		chk(b, 8'h00);
		wrt(4'h3, 8'h05);
		rdb(4'h3);
		chk(b, 8'h05);
		$display("test registers done");
		wrt(4'h6, 8'h00);
		@(posedge clk);
		run <= 1'b1;
		wrt(4'h0, 8'h45);
		rdb(4'h0);
		chk(b, 8'h45);
		repeat (200) @(posedge clk);
		#1 chk(irq, 1'b0);
		rdb(4'h5);
		chk(b[0], 1'b1);
		wrt(4'h6, 8'h01);
		repeat (3) @(posedge clk);
		#1 chk(irq, 1'b1);
		$display("test mask done");
		cap(4'h4, 1);
		cap(4'h5, 1);
		cap(4'h6, 4);
		cap(4'h7, 16);
		$display("test capture done");
		@(posedge clk);
		run <= 1'b0;
		r = nxt(r);
		wrt(4'h2, 8'h01);
		wrt(4'h1, {1'b0, r[6:0]});
		for (int i = 0; i < 4; i++) begin
			wrt(4'h8, 8'h00);
			wrt(4'h7, 8'h00);
			wrt(4'h5, 8'h01);
			wrt(4'h0, {4'h0, cm[i]});
			wt(0);
			// entering a compare mode presets the pin: high for clear, low otherwise
			p = pin_next(cm[i] == 4'h9, cm[i]);
			repeat (2) @(posedge clk);
			#1 chk(pin_out, p);
			chk(pin_oe, 1'b1);
			rdb(4'h8);
			chk(b, 8'h01);
		end
		wrt(4'h8, 8'h00);
		wrt(4'h7, 8'h00);
		wrt(4'h0, 8'h0b);
		wt(1);
		rdb(4'h8);
		chk(b, 8'h00);
		rdb(4'h7);
		chk(b[7:4], 4'h0);
		$display("test compare done");
		wrt(4'h0, 8'h4c);
		repeat (4) @(posedge clk);
		#1 chk(bridge_out[0], 1'b1);
		chk(bridge_out[2:1], 2'h0);
		wrt(4'h4, 8'h01);
		@(posedge clk);
		shutdown_in <= 1'b1;
		rdb(4'h4);
		rdb(4'h4);
		chk(b[7], 1'b1);
		rdb(4'h5);
		chk(b[1], 1'b1);
		chk(bridge_out, 4'h0);
		chk(pin_out, 1'b0);
		$display("test pwm done");
		// half bridge: fault must be gone before the latch can be cleared
		@(posedge clk);
		shutdown_in <= 1'b0;
		wrt(4'h4, 8'h00);
		wrt(4'h1, 8'h40);
		wrt(4'h0, 8'h8c);
		repeat (300) @(posedge clk);
		zr = 8'h00;
		nov = 0;
		na = 0;
		nb = 0;
		seen = 1'b0;
		// first gap may be cut by the start of the window, so it is skipped
		for (int i = 0; i < 600; i++) begin
			@(posedge clk);
			#1;
			if (bridge_out[1:0] == 2'h3)
				nov++;
			if (bridge_out[1:0] == 2'h0) begin
				zr = zr + 8'h01;
			end else begin
				if (seen && zr != 8'h00)
					chk(zr >= 8'h05, 1'b1);
				seen = 1'b1;
				zr = 8'h00;
				na = na + bridge_out[0];
				nb = nb + bridge_out[1];
			end
		end
		chk(nov == 0, 1'b1);
		chk(na > 0 && nb > 0, 1'b1);
		$display("test half bridge done");
		close_out;
	end
endmodule
`default_nettype wire
